// ---- rtl/tmr8_pkg.sv ----
// Package: constants for the eight-bit timer with input capture
package tmr8_pkg;
    // Counter width and reload value
    localparam int CNT_W = 8;
    localparam logic [7:0] CNT_RELOAD = 8'hfc;
    localparam logic [7:0] CNT_MAX = 8'hff;
    // Clock select encodings
    localparam logic [1:0] CLK_DIV4 = 2'h0;
    localparam logic [1:0] CLK_DIV2 = 2'h1;
    localparam logic [1:0] CLK_DIV8 = 2'h2;
    localparam logic [1:0] CLK_OSC = 2'h3;
    // Prescaler terminal counts (divide minus one)
    localparam logic [12:0] PRE_DIV2 = 13'h0001;
    localparam logic [12:0] PRE_DIV4 = 13'h0003;
    localparam logic [12:0] PRE_DIV8 = 13'h0007;
    localparam int OSC_DIV = 8000;
    localparam logic [12:0] PRE_OSC = 13'(OSC_DIV - 1);
    // Edge select encoding
    localparam logic EDGE_FALL = 1'b0;
    localparam logic EDGE_RISE = 1'b1;
    // Level of an input pin that is not bonded out
    localparam logic UNBONDED_LEVEL = 1'b1;
    // Reset value of the status flags
    localparam logic FLAG_RESET = 1'b0;
endpackage

// ---- rtl/tmr8_capture.sv ----
// Capture channel: synchroniser, edge detect, capture register and flag
`timescale 1ns/100ps
module tmr8_capture (
    // Clock and reset
    input wire logic mclk,
    input wire logic srst,
    // Pin and configuration
    input wire logic pin,
    input wire logic bonded,
    input wire logic edge_sel,
    input wire logic enable,
    // Counter and flag clearing
    input wire logic [7:0] count,
    input wire logic clear_req,
    // Results
    output logic [7:0] value,
    output logic flag,
    output logic event_seen
);
    logic sync1; // First stage, read only by sync2
    logic sync2; // Second stage
    logic sync3; // Third stage
    logic level; // Accepted pin level
    logic pin_lvl; // Pin as seen after bond check
    logic rise; // Qualified rising transition
    logic fall; // Qualified falling transition
    logic hit; // Active transition on this channel

    // Non-bonded pin reads as one
    assign pin_lvl = bonded ? pin : tmr8_pkg::UNBONDED_LEVEL; // RL20

    // Three-stage synchroniser
    always_ff @(posedge mclk) begin
        if (srst) begin
            sync1 <= tmr8_pkg::UNBONDED_LEVEL;
            sync2 <= tmr8_pkg::UNBONDED_LEVEL;
            sync3 <= tmr8_pkg::UNBONDED_LEVEL;
        end else begin
            sync1 <= pin_lvl;
            sync2 <= sync1;
            sync3 <= sync2;
        end
    end

    // Accepted level moves only once stages two and three agree
    always_ff @(posedge mclk) begin
        if (srst) begin
            level <= tmr8_pkg::UNBONDED_LEVEL;
        end else if (sync2 == sync3) begin
            level <= sync3;
        end
    end

    // A change counts once stages two and three agree; a one-cycle glitch is dropped
    assign rise = (sync2 == sync3) & sync3 & ~level;
    assign fall = (sync2 == sync3) & ~sync3 & level;
    // Only the transition picked by edge_sel is taken, and only while enabled
    assign hit = enable & ((edge_sel == tmr8_pkg::EDGE_RISE) ? rise : fall); // RL12 RL19 RL21

    // Capture register, always overwritten by the latest event
    always_ff @(posedge mclk) begin
        if (srst) begin
            value <= 8'h00;
        end else if (hit) begin
            value <= count; // RL11 RL13 RL16
        end
    end

    // Flag: a new event wins over a clear in the same cycle
    always_ff @(posedge mclk) begin
        if (srst) begin
            flag <= tmr8_pkg::FLAG_RESET;
        end else if (hit) begin
            flag <= 1'b1; // RL13
        end else if (clear_req) begin
            flag <= 1'b0; // RL15
        end
    end

    // One-cycle marker of an event, for the parent
    always_ff @(posedge mclk) begin
        if (srst) begin
            event_seen <= 1'b0;
        end else begin
            event_seen <= hit;
        end
    end
endmodule // tmr8_capture

// ---- rtl/tmr8_timer.sv ----
// Top: eight-bit free-running counter with overflow and two capture channels
//
// What this block does
// RL1: Free-running 8-bit counter, prescaled tick source.
// RL2: Two counter reads; alternate never touches overflow.
// RL3: Writing either counter register reloads FCh.
// RL4: Reset and only reload value is FCh.
// RL5: FFh to 00h wrap sets overflow flag.
// RL6: Overflow irq needs enable and clear mask.
// RL7: Status read then main counter access clears.
// RL8: Alternate counter access leaves overflow unchanged.
// RL9: Timer keeps running in wait state.
// RL10: Halt stops counter; resumes from held value.
// RL11: Two capture registers latch counter on edge.
// RL12: Each capture input has own edge select.
// RL13: Capture event sets flag and loads value.
// RL14: One capture irq enable covers both channels.
// RL15: Status read then capture access clears flag.
// RL16: New capture overwrites older unread value.
// RL17: Both channels capture concurrently without interference.
// RL18: One-pulse or PWM leaves only channel b.
// RL19: Capture pins feed timer directly, except channel a in one-pulse or PWM.
// RL20: Unbonded timer input reads as one.
// RL21: Edge select zero falling, one rising.
// RL22: Disable bit freezes prescaler and counter.
// RL23: Clock select 00 /4, 01 /2, 10 /8, 11 osc.
`timescale 1ns/100ps
module tmr8_timer #(
    parameter int OSC_DIV = tmr8_pkg::OSC_DIV // Oscillator divide, shortenable
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic srst,
    // Halved oscillator clock as a level; each rising edge is one source tick
    input wire logic halved_osc_clock,
    // Processor state
    input wire logic wait_mode,
    input wire logic halt_mode,
    input wire logic cpu_irq_mask,
    // Configuration bits
    input wire logic [1:0] clock_select_field,
    input wire logic timer_disable_bit,
    input wire logic overflow_irq_enable,
    input wire logic capture_irq_enable,
    input wire logic capture_edge_sel_a,
    input wire logic capture_edge_sel_b,
    input wire logic one_pulse_mode,
    input wire logic pwm_mode,
    // Register access strobes, one cycle each
    input wire logic status_read,
    input wire logic counter_access,
    input wire logic counter_write,
    input wire logic alt_counter_access,
    input wire logic alt_counter_write,
    input wire logic capture_a_access,
    input wire logic capture_b_access,
    // Capture pins
    input wire logic capture_pin_a,
    input wire logic capture_pin_b,
    input wire logic capture_pin_a_bonded,
    input wire logic capture_pin_b_bonded,
    // Register values
    output logic [7:0] counter_value_reg,
    output logic [7:0] alt_counter_value_reg,
    output logic [7:0] capture_value_a,
    output logic [7:0] capture_value_b,
    // Status flags
    output logic overflow_flag,
    output logic capture_flag_a,
    output logic capture_flag_b,
    // Interrupt requests
    output logic overflow_irq,
    output logic capture_irq
);
    localparam logic [12:0] PRE_OSC = 13'(OSC_DIV - 1); // Oscillator terminal count

    logic [12:0] pre_cnt; // Prescaler count
    logic [12:0] pre_top; // Terminal count for the selected source
    logic osc_sync1; // Oscillator tick, stage one
    logic osc_sync2; // Oscillator tick, stage two
    logic osc_sync3; // Oscillator tick, stage three
    logic osc_lvl; // Accepted oscillator level
    logic osc_tick; // One-cycle oscillator edge
    logic src_tick; // Input to prescaler this cycle
    logic tick; // Counter advance enable
    logic run; // Timer allowed to count
    logic [7:0] count; // Free-running counter
    logic reload; // Software reload request
    logic wrap; // Counter wraps this cycle
    logic tof_armed; // Status seen with overflow set
    logic ica_armed; // Status seen with capture a set
    logic icb_armed; // Status seen with capture b set
    logic cap_a_en; // Channel a usable
    logic flag_a; // Channel a flag
    logic flag_b; // Channel b flag
    logic [7:0] val_a; // Channel a value
    logic [7:0] val_b; // Channel b value
    logic seen_a; // Channel a event marker
    logic seen_b; // Channel b event marker

    // Wait state not considered: only halt and disable stop counting
    assign run = ~timer_disable_bit & ~halt_mode; // RL9 RL10 RL22

    // Oscillator tick crosses in through three flops
    always_ff @(posedge mclk) begin
        if (srst) begin
            osc_sync1 <= 1'b0;
            osc_sync2 <= 1'b0;
            osc_sync3 <= 1'b0;
        end else begin
            osc_sync1 <= halved_osc_clock;
            osc_sync2 <= osc_sync1;
            osc_sync3 <= osc_sync2;
        end
    end

    // Accepted oscillator level, moves once stages two and three agree
    always_ff @(posedge mclk) begin
        if (srst) begin
            osc_lvl <= 1'b0;
        end else if (osc_sync2 == osc_sync3) begin
            osc_lvl <= osc_sync3;
        end
    end
    // Source must stay high two cycles or the rise is not counted
    assign osc_tick = (osc_sync2 == osc_sync3) & osc_sync3 & ~osc_lvl;

    // Clock select decode
    always_comb begin
        case (clock_select_field)
            tmr8_pkg::CLK_DIV4: pre_top = tmr8_pkg::PRE_DIV4; // RL23
            tmr8_pkg::CLK_DIV2: pre_top = tmr8_pkg::PRE_DIV2; // RL23
            tmr8_pkg::CLK_DIV8: pre_top = tmr8_pkg::PRE_DIV8; // RL23
            default: pre_top = PRE_OSC; // RL23
        endcase
    end
    assign src_tick = (clock_select_field == tmr8_pkg::CLK_OSC) ? osc_tick : 1'b1;

    // Prescaler, frozen while stopped; restarts on reload
    always_ff @(posedge mclk) begin
        if (srst || reload) begin
            pre_cnt <= 13'h0000;
        end else if (run && src_tick) begin
            if (pre_cnt >= pre_top) begin
                pre_cnt <= 13'h0000; // RL1
            end else begin
                pre_cnt <= pre_cnt + 13'h0001;
            end
        end
    end
    assign tick = run && src_tick && (pre_cnt >= pre_top);

    // Either counter register write reloads
    assign reload = counter_write | alt_counter_write; // RL3
    assign wrap = tick && (count == tmr8_pkg::CNT_MAX) && !reload;

    // Counter: reset and reload both load FCh
    always_ff @(posedge mclk) begin
        if (srst) begin
            count <= tmr8_pkg::CNT_RELOAD; // RL4
        end else if (reload) begin
            count <= tmr8_pkg::CNT_RELOAD; // RL3 RL4
        end else if (tick) begin
            count <= count + 8'h01; // RL1 RL5
        end
    end

    // Both read ports mirror the counter
    always_ff @(posedge mclk) begin
        if (srst) begin
            counter_value_reg <= tmr8_pkg::CNT_RELOAD;
            alt_counter_value_reg <= tmr8_pkg::CNT_RELOAD;
        end else begin
            counter_value_reg <= count; // RL2
            alt_counter_value_reg <= count; // RL2
        end
    end

    // Arming: status read while flag is set; kept until the matching access
    always_ff @(posedge mclk) begin
        if (srst) begin
            tof_armed <= 1'b0;
        end else if (counter_access) begin
            tof_armed <= 1'b0;
        end else if (status_read && overflow_flag) begin
            tof_armed <= 1'b1; // RL7
        end
    end

    // Overflow flag: wrap wins over clear; alternate access is ignored
    always_ff @(posedge mclk) begin
        if (srst) begin
            overflow_flag <= tmr8_pkg::FLAG_RESET;
        end else if (wrap) begin
            overflow_flag <= 1'b1; // RL5
        end else if (counter_access && tof_armed) begin
            overflow_flag <= 1'b0; // RL7 RL8
        end
    end

    // Channel a is taken over by one-pulse and PWM operation
    assign cap_a_en = ~one_pulse_mode & ~pwm_mode; // RL18

    // Capture arming per channel
    always_ff @(posedge mclk) begin
        if (srst) begin
            ica_armed <= 1'b0;
            icb_armed <= 1'b0;
        end else begin
            if (capture_a_access) begin
                ica_armed <= 1'b0;
            end else if (status_read && flag_a) begin
                ica_armed <= 1'b1; // RL15
            end
            if (capture_b_access) begin
                icb_armed <= 1'b0;
            end else if (status_read && flag_b) begin
                icb_armed <= 1'b1; // RL15
            end
        end
    end

    // Independent channels share only the counter
    tmr8_capture u_cap_a ( // RL17
        .mclk(mclk),
        .srst(srst),
        .pin(capture_pin_a),
        .bonded(capture_pin_a_bonded),
        .edge_sel(capture_edge_sel_a),
        .enable(cap_a_en),
        .count(count),
        .clear_req(capture_a_access && ica_armed),
        .value(val_a),
        .flag(flag_a),
        .event_seen(seen_a)
    );
    tmr8_capture u_cap_b (
        .mclk(mclk),
        .srst(srst),
        .pin(capture_pin_b),
        .bonded(capture_pin_b_bonded),
        .edge_sel(capture_edge_sel_b),
        .enable(1'b1),
        .count(count),
        .clear_req(capture_b_access && icb_armed),
        .value(val_b),
        .flag(flag_b),
        .event_seen(seen_b)
    );

    // Capture outputs registered once more
    always_ff @(posedge mclk) begin
        if (srst) begin
            capture_value_a <= 8'h00;
            capture_value_b <= 8'h00;
            capture_flag_a <= 1'b0;
            capture_flag_b <= 1'b0;
        end else begin
            capture_value_a <= val_a;
            capture_value_b <= val_b;
            capture_flag_a <= flag_a;
            capture_flag_b <= flag_b;
        end
    end

    // Requests stay pending in the flags until enable and mask allow
    always_ff @(posedge mclk) begin
        if (srst) begin
            overflow_irq <= 1'b0;
            capture_irq <= 1'b0;
        end else begin
            overflow_irq <= overflow_flag & overflow_irq_enable & ~cpu_irq_mask; // RL6
            capture_irq <= (flag_a | flag_b) & capture_irq_enable & ~cpu_irq_mask; // RL14
        end
    end

    // Wrap sets the flag in the next cycle
    AST_WRAP_SETS_FLAG: assert property (@(posedge mclk) disable iff (srst) // RL5
        wrap |=> overflow_flag && count == 8'h00)
        else $error("Overflow flag not set after wrap");

    // Reload gives FCh
    AST_RELOAD_FC: assert property (@(posedge mclk) disable iff (srst) // RL3
        reload |=> count == 8'hfc)
        else $error("Counter not reloaded to FCh");

    // Alternate access alone never clears overflow
    AST_ALT_KEEPS_FLAG: assert property (@(posedge mclk) disable iff (srst) // RL8
        overflow_flag && alt_counter_access && !counter_access |=> overflow_flag)
        else $error("Alternate access cleared overflow");

    // Main access without prior status read leaves the flag
    AST_NO_ARM_NO_CLEAR: assert property (@(posedge mclk) disable iff (srst) // RL7
        overflow_flag && !tof_armed && counter_access |=> overflow_flag)
        else $error("Overflow cleared without status read");

    // Two-step clear
    sequence seq_arm;
        status_read && overflow_flag && !counter_access ##1 counter_access && !wrap;
    endsequence
    AST_TWO_STEP_CLEAR: assert property (@(posedge mclk) disable iff (srst) // RL7
        seq_arm |=> !overflow_flag)
        else $error("Two-step clear failed");

    // Stopped counter holds
    AST_FREEZE: assert property (@(posedge mclk) disable iff (srst) // RL22
        !run && !reload |=> $stable(count))
        else $error("Counter moved while stopped");

    // Overflow request follows flag, enable and mask
    AST_OVF_IRQ: assert property (@(posedge mclk) disable iff (srst) // RL6
        overflow_irq |-> $past(overflow_flag) && $past(overflow_irq_enable) && !$past(cpu_irq_mask))
        else $error("Overflow request without cause");

    // Channel a idle in one-pulse or PWM
    AST_CAP_A_BLOCKED: assert property (@(posedge mclk) disable iff (srst) // RL18
        !cap_a_en |=> !seen_a)
        else $error("Channel a captured in pulse mode");

    // Capture flag set follows an event
    AST_CAP_B_FLAG: assert property (@(posedge mclk) disable iff (srst) // RL13
        seen_b |-> flag_b)
        else $error("Channel b flag missing after capture");

    // Wait state does not hold the counter back
    AST_WAIT_RUNS: assert property (@(posedge mclk) disable iff (srst) // RL9
        wait_mode && tick && !reload |=> count == $past(count) + 8'h01)
        else $error("Counter stalled in wait state");

    // Counter leaves reset at FCh with the flag clear
    AST_RESET_FC: assert property (@(posedge mclk) // RL4
        $fell(srst) |-> count == tmr8_pkg::CNT_RELOAD && !overflow_flag)
        else $error("Counter not at FCh after reset");

    // Capture request follows either flag, enable and mask
    AST_CAP_IRQ: assert property (@(posedge mclk) disable iff (srst) // RL14
        capture_irq |-> $past(flag_a | flag_b) && $past(capture_irq_enable) && !$past(cpu_irq_mask))
        else $error("Capture request without cause");

    // Channel a event loads the count seen at the event and sets the flag
    AST_CAP_A_VALUE: assert property (@(posedge mclk) disable iff (srst) // RL13
        seen_a |-> val_a == $past(count) && flag_a)
        else $error("Channel a value or flag wrong after capture");

    // Overflow flag only falls on a main counter access
    AST_OVF_ONLY_MAIN: assert property (@(posedge mclk) disable iff (srst) // RL7
        overflow_flag && !counter_access |=> overflow_flag)
        else $error("Overflow flag fell without main access");
endmodule // tmr8_timer

// ---- test/tmr8_pin_model.sv ----
// Partner model: source of the two capture pins
`timescale 1ns/100ps
module tmr8_pin_model (
    // Clock
    input wire logic mclk,
    // Pins toward the timer, idle high
    output logic pin_a = 1'b1,
    output logic pin_b = 1'b1
);
    // Move a pin (2 moves both) just after an edge, then hold it
    task automatic drive(input int ch, input logic lvl, input int hold);
        @(posedge mclk);
        if (ch != 1) pin_a <= lvl;
        if (ch != 0) pin_b <= lvl;
        repeat (hold) @(posedge mclk);
    endtask
endmodule // tmr8_pin_model

// ---- test/tb.sv ----
// Testbench: eight-bit timer with capture, checked against a bench model
`timescale 1ns/100ps
module tb;
    // Clock, reset and processor state
    logic mclk = 1'b0;
    logic srst = 1'b1;
    logic halved_osc_clock = 1'b0;
    logic osc_half = 1'b0;
    logic wait_mode = 1'b0;
    logic halt_mode = 1'b0;
    logic mask = 1'b0;
    // Configuration bits
    logic [1:0] sel = 2'h1;
    logic dis = 1'b0;
    logic oie = 1'b0;
    logic cie = 1'b0;
    logic [1:0] esel = 2'h0;
    logic opm = 1'b0;
    logic pwm = 1'b0;
    logic [1:0] bnd = 2'h3;
    // Strobes: status, ctr, ctr wr, alt, alt wr, cap a, cap b
    logic [6:0] strb = 7'h00;
    // Pins and design outputs
    logic capture_pin_a, capture_pin_b;
    logic [7:0] counter_value_reg, alt_counter_value_reg, capture_value_a, capture_value_b;
    logic overflow_flag, capture_flag_a, capture_flag_b, overflow_irq, capture_irq;
    // Bench model state
    int err_total = 0;
    int checks_done = 0;
    int mcnt = 'hfc;
    int r;
    logic mflag = 1'b0;
    logic [1:0] mfl = 2'h0;
    logic [1:0] mlev = 2'h3;
    logic [7:0] mval [2] = '{8'h00, 8'h00};

    // 20 MHz clock
    always #25 mclk = ~mclk;
    // Oscillator source, free running, one rise per four cycles
    always @(posedge mclk) begin
        osc_half <= ~osc_half;
        if (osc_half) halved_osc_clock <= ~halved_osc_clock;
    end

    // Short oscillator divide keeps the osc step at sixteen cycles
    tmr8_timer #(.OSC_DIV(4)) u_dut (
        .mclk, .srst, .halved_osc_clock, .wait_mode, .halt_mode,
        .cpu_irq_mask(mask), .clock_select_field(sel), .timer_disable_bit(dis),
        .overflow_irq_enable(oie), .capture_irq_enable(cie),
        .capture_edge_sel_a(esel[0]), .capture_edge_sel_b(esel[1]),
        .one_pulse_mode(opm), .pwm_mode(pwm),
        .status_read(strb[0]), .counter_access(strb[1]), .counter_write(strb[2]),
        .alt_counter_access(strb[3]), .alt_counter_write(strb[4]),
        .capture_a_access(strb[5]), .capture_b_access(strb[6]),
        .capture_pin_a, .capture_pin_b,
        .capture_pin_a_bonded(bnd[0]), .capture_pin_b_bonded(bnd[1]),
        .counter_value_reg, .alt_counter_value_reg, .capture_value_a, .capture_value_b,
        .overflow_flag, .capture_flag_a, .capture_flag_b, .overflow_irq, .capture_irq
    );
    // Far-side pin source
    tmr8_pin_model u_pins (.mclk, .pin_a(capture_pin_a), .pin_b(capture_pin_b));

    // Verdict and end of run
    task automatic tally_and_finish();
        $display("COUNTS checks=%0d mismatches=%0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // Four-state compare, reported at once
    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        checks_done++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    // Let edges pass, then sample settled outputs
    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask

    // One-cycle strobe pattern
    task automatic acc(input logic [6:0] m);
        @(posedge mclk);
        strb <= m;
        @(posedge mclk);
        strb <= 7'h00;
    endtask

    // Two strobe patterns on back-to-back edges
    task automatic acc2(input logic [6:0] m1, input logic [6:0] m2);
        @(posedge mclk);
        strb <= m1;
        @(posedge mclk);
        strb <= m2;
        @(posedge mclk);
        strb <= 7'h00;
    endtask

    // Bounded wait for the counter to leave a value
    task automatic wait_change(input logic [7:0] last, output int gap);
        gap = 0;
        while (counter_value_reg === last && gap < 2000) begin
            tick(1);
            gap++;
        end
        if (gap == 2000) begin
            err_total++;
            $display("MISMATCH t=%0t counter stuck", $time);
            tally_and_finish();
        end
    endtask

    // Reload, then follow n steps; gaps after the first give the divide
    task automatic steps(input int div, input int n);
        int gap;
        acc(7'h06);
        mcnt = 'hfc;
        tick(1);
        chk(counter_value_reg, 8'hfc, "reload");
        for (int i = 0; i < n; i++) begin
            wait_change(mcnt[7:0], gap);
            mcnt = (mcnt + 1) % 256;
            if (mcnt == 0) mflag = 1'b1;
            chk(counter_value_reg, mcnt[7:0], "count");
            chk(alt_counter_value_reg, mcnt[7:0], "alt");
            chk({7'h0, overflow_flag}, {7'h0, mflag}, "ovf");
            if (i > 0) chk(gap[7:0], div[7:0], "period");
        end
    endtask

    // Capture results against the model
    task automatic cmp_all();
        chk(capture_value_a, mval[0], "cap a");
        chk(capture_value_b, mval[1], "cap b");
        chk({6'h0, capture_flag_b, capture_flag_a}, {6'h0, mfl}, "cap flags");
        chk({7'h0, capture_irq}, {7'h0, cie & (|mfl) & ~mask}, "cap irq");
        chk({7'h0, overflow_flag}, {7'h0, mflag}, "ovf");
    endtask

    // Move a pin (2 = both); counter is frozen so the capture is exact
    task automatic pin(input int ch, input logic lvl);
        logic nl;
        for (int c = 0; c < 2; c++) begin
            if (c == ch || ch == 2) begin
                nl = bnd[c] ? lvl : 1'b1;
                if (nl != mlev[c] && nl == esel[c] && !(c == 0 && (opm || pwm))) begin
                    mval[c] = mcnt[7:0];
                    mfl[c] = 1'b1;
                end
                mlev[c] = nl;
            end
        end
        u_pins.drive(ch, lvl, 8);
        tick(0);
        cmp_all();
    endtask

    // Capture access, with or without the status read first
    task automatic clr(input int c, input logic stat);
        if (stat) acc2(7'h01, c ? 7'h40 : 7'h20);
        else acc(c ? 7'h40 : 7'h20);
        tick(2);
        if (stat) mfl[c] = 1'b0;
        cmp_all();
    endtask

    // Main sequence
    initial begin
        void'($urandom(46478));
        repeat (6) @(posedge mclk);
        srst <= 1'b0;
        tick(1);
        chk(counter_value_reg, 8'hfc, "rst");
        cmp_all();
        chk({7'h0, overflow_irq}, 8'h00, "rst irq");
        $display("TEST reset done");
        // Every clock select, in the wait state
        @(posedge mclk);
        wait_mode <= 1'b1;
        for (int k = 0; k < 4; k++) begin
            @(posedge mclk);
            sel <= 2'(k);
            steps(k == 1 ? 2 : (k == 0 ? 4 : (k == 2 ? 8 : 16)), 6);
        end
        $display("TEST clock select done");
        // Overflow request and two-step clear, timer frozen
        @(posedge mclk);
        dis <= 1'b1;
        sel <= 2'h2;
        tick(3);
        chk({7'h0, overflow_irq}, 8'h00, "irq off");
        @(posedge mclk);
        oie <= 1'b1;
        tick(3);
        chk({7'h0, overflow_irq}, {7'h0, mflag}, "irq on");
        @(posedge mclk);
        mask <= 1'b1;
        tick(3);
        chk({7'h0, overflow_irq}, 8'h00, "irq masked");
        acc(7'h02);
        tick(2);
        chk({7'h0, overflow_flag}, 8'h01, "no status");
        acc(7'h01);
        acc(7'h08);
        acc(7'h18);
        tick(2);
        chk({7'h0, overflow_flag}, 8'h01, "alt kept");
        acc2(7'h01, 7'h02);
        tick(2);
        mflag = 1'b0;
        chk({7'h0, overflow_flag}, 8'h00, "cleared");
        @(posedge mclk);
        mask <= 1'b0;
        tick(20);
        chk(counter_value_reg, 8'hfc, "frozen");
        $display("TEST overflow done");
        // Halt holds the count, release resumes from it
        @(posedge mclk);
        halt_mode <= 1'b1;
        dis <= 1'b0;
        tick(30);
        chk(counter_value_reg, 8'hfc, "halt");
        @(posedge mclk);
        halt_mode <= 1'b0;
        wait_change(8'hfc, r);
        chk(counter_value_reg, 8'hfd, "resume");
        $display("TEST halt done");
        // Freeze at a random count, capture on every edge select
        @(posedge mclk);
        cie <= 1'b1;
        r = $urandom_range(5, 40);
        steps(8, r);
        @(posedge mclk);
        dis <= 1'b1;
        for (int k = 0; k < 4; k++) begin
            @(posedge mclk);
            esel <= {2{k[1]}};
            tick(1);
            for (int j = 0; j < 3; j++) pin(k % 2, k[1] ^ j[0]);
        end
        acc(7'h06);
        mcnt = 'hfc;
        pin(2, 1'b0);
        pin(2, 1'b1);
        clr(0, 1'b0);
        clr(0, 1'b1);
        clr(1, 1'b1);
        $display("TEST capture done");
        // One-pulse, then PWM: only channel b captures
        for (int m = 0; m < 2; m++) begin
            @(posedge mclk);
            opm <= (m == 0);
            pwm <= (m == 1);
            cie <= (m == 1);
            tick(1);
            pin(2, 1'b0);
            pin(2, 1'b1);
            clr(1, 1'b1);
        end
        $display("TEST modes done");
        // Unbonded pin reads high, so its edges go unseen
        @(posedge mclk);
        opm <= 1'b0;
        pwm <= 1'b0;
        bnd <= 2'h2;
        tick(1);
        pin(0, 1'b0);
        pin(0, 1'b1);
        $display("TEST unbonded done");
        tally_and_finish();
    end
endmodule // tb
